// *** common/gps_pins_pkg.sv ***
// Constants shared by the GPS module control pin logic.
package gps_pins_pkg;
    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned CLK_PERIOD_NS = 50;
    // Timing pulse default width in nanoseconds (4.2 us).
    localparam int unsigned PULSE_WIDTH_NS = 4200;
    localparam logic [31:0] PULSE_WIDTH_CYC = 32'((PULSE_WIDTH_NS + CLK_PERIOD_NS - 1)
                                                 / CLK_PERIOD_NS);
    // One second in clock cycles.
    localparam logic [31:0] SECOND_CYC = 32'(CLK_HZ);
    // Least hold of the external reset, in microseconds.
    localparam int unsigned EXT_RESET_MIN_US = 100;
    localparam logic [15:0] EXT_RESET_MIN_CYC = 16'(EXT_RESET_MIN_US * (CLK_HZ / 1000000));
    // Default baud rates.
    localparam int unsigned BAUD_A_DEFAULT = 38400;
    localparam int unsigned BAUD_B_DEFAULT = 4800;
    localparam logic [15:0] BAUD_DIV_A_RST = 16'(CLK_HZ / BAUD_A_DEFAULT);
    localparam logic [15:0] BAUD_DIV_B_RST = 16'(CLK_HZ / BAUD_B_DEFAULT);
    localparam int unsigned UART_DATA_BITS = 8;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_PULSE_WIDTH = 8'h08;
    localparam logic [7:0] REG_CABLE_DELAY = 8'h0c;
    localparam logic [7:0] REG_BAUD_A = 8'h10;
    localparam logic [7:0] REG_BAUD_B = 8'h14;
    localparam logic [7:0] REG_UART_A = 8'h18;
    localparam logic [7:0] REG_UART_B = 8'h1c;
    // Control fields.
    localparam int unsigned CTRL_POL_BIT = 0;
    localparam int unsigned CTRL_MODE_LSB = 1;
    localparam logic [2:0] CTRL_RST = 3'h0;
    // UART register fields.
    localparam int unsigned UART_BUSY_BIT = 8;
    localparam int unsigned UART_RXV_BIT = 9;

    // Antenna status codes.
    typedef enum logic [1:0] {
        ANT_NORMAL = 2'h0,
        ANT_OPEN = 2'h1,
        ANT_SHORT = 2'h2,
        ANT_UNDEF = 2'h3
    } ant_status_e;

    // Timing pulse modes.
    localparam logic [1:0] PULSE_MODE_ALWAYS = 2'h0;
    localparam logic [1:0] PULSE_MODE_OFF = 2'h1;
    localparam logic [1:0] PULSE_MODE_GATED = 2'h2;
endpackage

// *** rtl/gps_uart.sv ***
// One 8N1 serial port with a programmable bit divider.
`timescale 1ns/1ns
module gps_uart #(
    parameter int DIV_W = 16
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bit divider in clock cycles.
    input wire logic [DIV_W-1:0] bit_div,
    // Transmit request.
    input wire logic tx_start,
    input wire logic [7:0] tx_data,
    output logic tx_busy,
    // Receive result.
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_clear,
    // Pins; rxd must already be synchronised.
    input wire logic rxd,
    output logic txd
);
    logic [DIV_W-1:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_shift;
    logic [DIV_W-1:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [8:0] rx_shift;
    logic rx_act;

    // Transmitter: start, eight data bits lsb first, one stop bit.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_busy <= 1'b0;
            txd <= 1'b1;
            tx_cnt <= '0;
            tx_bit <= 4'h0;
            tx_shift <= 10'h3ff;
        end else if (!tx_busy) begin
            if (tx_start) begin
                tx_busy <= 1'b1;
                txd <= 1'b0;
                tx_shift <= {1'b1, 1'b1, tx_data};
                tx_cnt <= bit_div;
                tx_bit <= 4'h9;
            end
        end else if (tx_cnt > 1) begin
            tx_cnt <= tx_cnt - 1'b1;
        end else if (tx_bit == 4'h0) begin
            tx_busy <= 1'b0;
        end else begin
            txd <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[9:1]};
            tx_cnt <= bit_div;
            tx_bit <= tx_bit - 1'b1;
        end
    end

    // Receiver samples mid-bit; a new byte wins over a clear.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_act <= 1'b0;
            rx_cnt <= '0;
            rx_bit <= 4'h0;
            rx_shift <= 9'h000;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            if (rx_clear) begin
                rx_valid <= 1'b0;
            end
            if (!rx_act) begin
                if (!rxd) begin
                    rx_act <= 1'b1;
                    rx_cnt <= bit_div >> 1;
                    rx_bit <= 4'h0;
                end
            end else if (rx_cnt > 1) begin
                rx_cnt <= rx_cnt - 1'b1;
            end else begin
                rx_cnt <= bit_div;
                rx_shift <= {rxd, rx_shift[8:1]};
                rx_bit <= rx_bit + 1'b1;
                if (rx_bit == 4'h0 && rxd) begin
                    rx_act <= 1'b0; // False start bit.
                end else if (rx_bit == 4'h9) begin
                    rx_act <= 1'b0;
                    if (rxd) begin
                        rx_data <= rx_shift[8:1];
                        rx_valid <= 1'b1;
                    end
                end
            end
        end
    end
endmodule

// *** rtl/gps_pins_ctrl.sv ***
// Pin control, antenna status, timing pulse and serial ports of the GPS module.
// Notes on behaviour
// - Run while run/standby input is high; standby while it is low.
// - Amplifier enable output low when running, high in standby.
// - Low on reset input resets the module.
// - Decode short/open: 11 open, 10 normal, 00 shorted, 01 undefined.
// - Short input pulled up, reads high when unconnected.
// - Floating open input reports antenna open.
// - Timing pulse once per second.
// - Positive pulse, default 4.2 us wide, width adjustable.
// - Host sets pulse polarity and cable delay offset.
// - Host selects timing pulse mode.
// - Two serial ports with software-set baud rates.
// - Fixed 8N1 frame, no flow control.
// - Defaults: 38400 baud primary, 4800 baud secondary.
`timescale 1ns/1ns
module gps_pins_ctrl #(
    parameter logic [31:0] SECOND_CYCLES = gps_pins_pkg::SECOND_CYC,
    parameter logic [15:0] EXT_RESET_CYCLES = gps_pins_pkg::EXT_RESET_MIN_CYC
) (
    // Clock and power-on reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control and antenna pins.
    input wire logic ext_reset_n,
    input wire logic run_standby,
    input wire logic ant_open,
    input wire logic ant_short,
    output logic ext_amp_enable_n,
    output logic pps,
    // Serial pins.
    input wire logic rxd_a,
    input wire logic rxd_b,
    output logic txd_a,
    output logic txd_b,
    // Status outputs.
    output logic standby,
    output logic [1:0] ant_status,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [1:0] rst_sync, stby_sync, open_sync, short_sync, rxa_sync, rxb_sync;

    // Two stages for every pin; only stage [1] is read downstream.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'b11;
            stby_sync <= 2'b11;
            open_sync <= 2'b11;
            short_sync <= 2'b11;
            rxa_sync <= 2'b11;
            rxb_sync <= 2'b11;
        end else begin
            rst_sync <= {rst_sync[0], ext_reset_n};
            stby_sync <= {stby_sync[0], run_standby};
            open_sync <= {open_sync[0], ant_open};
            short_sync <= {short_sync[0], ant_short};
            rxa_sync <= {rxa_sync[0], rxd_a};
            rxb_sync <= {rxb_sync[0], rxd_b};
        end
    end

    // ****************************************************************
    // External reset qualification
    // ****************************************************************
    // A low must last the minimum hold before it resets; glitches are ignored.
    logic [15:0] xrst_cnt;
    logic soft_rst;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            xrst_cnt <= 16'h0000;
            soft_rst <= 1'b0;
        end else if (rst_sync[1]) begin
            xrst_cnt <= 16'h0000;
            soft_rst <= 1'b0;
        end else if (xrst_cnt >= EXT_RESET_CYCLES - 16'h0001) begin
            soft_rst <= 1'b1;
        end else begin
            xrst_cnt <= xrst_cnt + 16'h0001;
        end
    end

    // ****************************************************************
    // Run/standby and amplifier enable
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            standby <= 1'b0;
            ext_amp_enable_n <= 1'b0;
        end else begin
            standby <= ~stby_sync[1];
            ext_amp_enable_n <= ~stby_sync[1];
        end
    end

    // ****************************************************************
    // Antenna status
    // ****************************************************************
    // Pad pull-up on short, and an unconnected open pin floats high.
    logic [1:0] next_ant;
    always_comb begin
        unique case ({short_sync[1], open_sync[1]})
            2'b11: next_ant = gps_pins_pkg::ANT_OPEN;
            2'b10: next_ant = gps_pins_pkg::ANT_NORMAL;
            2'b00: next_ant = gps_pins_pkg::ANT_SHORT;
            2'b01: next_ant = gps_pins_pkg::ANT_UNDEF;
        endcase
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ant_status <= gps_pins_pkg::ANT_OPEN;
        end else begin
            ant_status <= next_ant;
        end
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [2:0] ctrl;
    logic [31:0] pulse_width, cable_delay;
    logic [15:0] baud_a, baud_b;
    logic wr_en, rd_en, tx_a_go, tx_b_go, clr_a, clr_b;
    logic tx_a_busy, tx_b_busy, rx_a_valid, rx_b_valid;
    logic [7:0] rx_a_data, rx_b_data;
    logic addr_ok;

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= gps_pins_pkg::REG_UART_B);
    assign tx_a_go = wr_en && paddr == gps_pins_pkg::REG_UART_A;
    assign tx_b_go = wr_en && paddr == gps_pins_pkg::REG_UART_B;
    // Only a read that returned the byte clears it, so a byte landing after setup is kept.
    assign clr_a = rd_en && paddr == gps_pins_pkg::REG_UART_A &&
                   prdata[gps_pins_pkg::UART_RXV_BIT];
    assign clr_b = rd_en && paddr == gps_pins_pkg::REG_UART_B &&
                   prdata[gps_pins_pkg::UART_RXV_BIT];

    // Writable settings; the external reset restores them as well.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= gps_pins_pkg::CTRL_RST;
            pulse_width <= gps_pins_pkg::PULSE_WIDTH_CYC;
            cable_delay <= 32'h0000_0000;
            baud_a <= gps_pins_pkg::BAUD_DIV_A_RST;
            baud_b <= gps_pins_pkg::BAUD_DIV_B_RST;
        end else if (soft_rst) begin
            ctrl <= gps_pins_pkg::CTRL_RST;
            pulse_width <= gps_pins_pkg::PULSE_WIDTH_CYC;
            cable_delay <= 32'h0000_0000;
            baud_a <= gps_pins_pkg::BAUD_DIV_A_RST;
            baud_b <= gps_pins_pkg::BAUD_DIV_B_RST;
        end else if (wr_en) begin
            unique case (paddr)
                gps_pins_pkg::REG_CTRL: ctrl <= pwdata[2:0];
                gps_pins_pkg::REG_PULSE_WIDTH: pulse_width <= pwdata;
                gps_pins_pkg::REG_CABLE_DELAY: cable_delay <= pwdata;
                gps_pins_pkg::REG_BAUD_A: baud_a <= pwdata[15:0];
                gps_pins_pkg::REG_BAUD_B: baud_b <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Single wait-free access: ready in every access phase.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    gps_pins_pkg::REG_CTRL: prdata <= {29'h0, ctrl};
                    gps_pins_pkg::REG_STATUS: prdata <= {29'h0, standby, ant_status};
                    gps_pins_pkg::REG_PULSE_WIDTH: prdata <= pulse_width;
                    gps_pins_pkg::REG_CABLE_DELAY: prdata <= cable_delay;
                    gps_pins_pkg::REG_BAUD_A: prdata <= {16'h0, baud_a};
                    gps_pins_pkg::REG_BAUD_B: prdata <= {16'h0, baud_b};
                    gps_pins_pkg::REG_UART_A: prdata <= {22'h0, rx_a_valid, tx_a_busy, rx_a_data};
                    gps_pins_pkg::REG_UART_B: prdata <= {22'h0, rx_b_valid, tx_b_busy, rx_b_data};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************************************
    // Timing pulse
    // ****************************************************************
    // Epoch counter runs even in standby so time is kept, but no pulse leaves.
    logic [31:0] sec_cnt, hi_cnt;
    logic pulse_on, epoch;
    logic [1:0] mode;
    assign mode = ctrl[gps_pins_pkg::CTRL_MODE_LSB +: 2];
    assign epoch = (sec_cnt == (cable_delay % SECOND_CYCLES));

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt <= 32'h0000_0000;
        end else if (soft_rst || sec_cnt >= SECOND_CYCLES - 32'h1) begin
            sec_cnt <= 32'h0000_0000;
        end else begin
            sec_cnt <= sec_cnt + 32'h1;
        end
    end

    // Cable delay shifts the pulse within the second; mode gates it.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_on <= 1'b0;
            hi_cnt <= 32'h0000_0000;
        end else if (soft_rst) begin
            pulse_on <= 1'b0;
            hi_cnt <= 32'h0000_0000;
        end else if (epoch && mode != gps_pins_pkg::PULSE_MODE_OFF && !standby &&
                     (mode != gps_pins_pkg::PULSE_MODE_GATED ||
                      ant_status == gps_pins_pkg::ANT_NORMAL)) begin
            pulse_on <= (pulse_width != 32'h0);
            hi_cnt <= pulse_width;
        end else if (hi_cnt > 32'h1) begin
            hi_cnt <= hi_cnt - 32'h1;
        end else begin
            pulse_on <= 1'b0;
            hi_cnt <= 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pps <= 1'b0;
        end else begin
            pps <= pulse_on ^ ctrl[gps_pins_pkg::CTRL_POL_BIT];
        end
    end

    // ****************************************************************
    // Serial ports
    // ****************************************************************
    logic uart_rst_n;
    logic txa_w, txb_w;
    assign uart_rst_n = rst_n & ~soft_rst;

    gps_uart #(.DIV_W(16)) u_uart_a (
        .ref_clk(ref_clk),
        .rst_n(uart_rst_n),
        .bit_div(baud_a),
        .tx_start(tx_a_go),
        .tx_data(pwdata[7:0]),
        .tx_busy(tx_a_busy),
        .rx_data(rx_a_data),
        .rx_valid(rx_a_valid),
        .rx_clear(clr_a),
        .rxd(rxa_sync[1]),
        .txd(txa_w)
    );

    gps_uart #(.DIV_W(16)) u_uart_b (
        .ref_clk(ref_clk),
        .rst_n(uart_rst_n),
        .bit_div(baud_b),
        .tx_start(tx_b_go),
        .tx_data(pwdata[7:0]),
        .tx_busy(tx_b_busy),
        .rx_data(rx_b_data),
        .rx_valid(rx_b_valid),
        .rx_clear(clr_b),
        .rxd(rxb_sync[1]),
        .txd(txb_w)
    );

    // Output flops on the serial lines keep every port registered here.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            txd_a <= 1'b1;
            txd_b <= 1'b1;
        end else begin
            txd_a <= txa_w;
            txd_b <= txb_w;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_amp_follows;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(stby_sync[1]) |=> !ext_amp_enable_n && !standby;
    endproperty
    a_amp_follows: assert property (p_amp_follows) else $error("amp enable wrong");

    property p_standby;
        @(posedge ref_clk) disable iff (!rst_n)
        !stby_sync[1] |=> standby;
    endproperty
    a_standby: assert property (p_standby) else $error("standby not entered");

    property p_ant_decode;
        @(posedge ref_clk) disable iff (!rst_n)
        (short_sync[1] && !open_sync[1]) |=> ant_status == gps_pins_pkg::ANT_NORMAL;
    endproperty
    a_ant_decode: assert property (p_ant_decode) else $error("antenna decode wrong");

    property p_ant_open;
        @(posedge ref_clk) disable iff (!rst_n)
        (short_sync[1] && open_sync[1]) |=> ant_status == gps_pins_pkg::ANT_OPEN;
    endproperty
    a_ant_open: assert property (p_ant_open) else $error("open not reported");

    property p_sync;
        @(posedge ref_clk) disable iff (!rst_n)
        1'b1 |=> stby_sync[1] == $past(stby_sync[0]);
    endproperty
    a_sync: assert property (p_sync) else $error("sync stage skipped");

    property p_xrst;
        @(posedge ref_clk) disable iff (!rst_n)
        soft_rst |-> !$past(rst_sync[1]) && xrst_cnt >= EXT_RESET_CYCLES - 16'h0001;
    endproperty
    a_xrst: assert property (p_xrst) else $error("early external reset");

    property p_pulse_start;
        @(posedge ref_clk) disable iff (!rst_n || soft_rst)
        $rose(pulse_on) |-> hi_cnt == $past(pulse_width);
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("pulse width load wrong");

    property p_pulse_pol;
        @(posedge ref_clk) disable iff (!rst_n)
        1'b1 |=> pps == ($past(pulse_on) ^ $past(ctrl[gps_pins_pkg::CTRL_POL_BIT]));
    endproperty
    a_pulse_pol: assert property (p_pulse_pol) else $error("pulse polarity wrong");

    property p_mode_off;
        @(posedge ref_clk) disable iff (!rst_n)
        (mode == gps_pins_pkg::PULSE_MODE_OFF && !pulse_on) |=> !pulse_on;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("pulse in off mode");
endmodule

// *** bench/gps_host_side.sv ***
// Far-side model: host reset and standby control, antenna detector and serial loopback.
`timescale 1ns/1ns
module gps_host_side (
    // Clock.
    input wire logic ref_clk,
    // Serial pins from the module.
    input wire logic txd_a,
    input wire logic txd_b,
    // Pins driven into the module.
    output logic ext_reset_n,
    output logic run_standby,
    output logic ant_open,
    output logic ant_short,
    output logic rxd_a,
    output logic rxd_b
);
    // ****************************************************************
    // Detector lines, loopback and host pins
    // ****************************************************************
    logic det_en = 1'b0;
    logic short_lvl = 1'b1;
    logic open_lvl = 1'b1;

    // An undriven short line sits on its pull-up; a floating open line reads high.
    assign ant_short = short_lvl | ~det_en;
    assign ant_open = open_lvl | ~det_en;
    // Each port hears its own frames, so both ends share one frame format and divider.
    assign rxd_a = txd_a;
    assign rxd_b = txd_b;

    // Host pins idle in run with the reset line released.
    initial begin
        ext_reset_n = 1'b1;
        run_standby = 1'b1;
    end

    task set_ant(input logic en, input logic s, input logic o);
        @(posedge ref_clk);
        det_en <= en;
        short_lvl <= s;
        open_lvl <= o;
    endtask

    task set_run(input logic r);
        @(posedge ref_clk);
        run_standby <= r;
    endtask

    // Holds the reset line low for the given number of cycles.
    task reset_pulse(input int n);
        @(posedge ref_clk);
        ext_reset_n <= 1'b0;
        repeat (n) @(posedge ref_clk);
        ext_reset_n <= 1'b1;
    endtask
endmodule

// *** bench/gps_pins_ctrl_bench.sv ***
// Self-checking bench for the GPS module control pins.
`timescale 1ns/1ns
module gps_pins_ctrl_bench;
    // ****************************************************************
    // Signals, design and far side
    // ****************************************************************
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    wire logic ext_reset_n, run_standby, ant_open, ant_short, rxd_a, rxd_b;
    wire logic ext_amp_enable_n, pps, txd_a, txd_b, standby, pready, pslverr;
    wire logic [1:0] ant_status;
    wire logic [31:0] prdata;
    int num_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int hi, r1, r2;
    logic [31:0] rd;
    logic err;

    gps_pins_ctrl #(.SECOND_CYCLES(32'd200), .EXT_RESET_CYCLES(16'd8)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
        .run_standby(run_standby), .ant_open(ant_open), .ant_short(ant_short),
        .ext_amp_enable_n(ext_amp_enable_n), .pps(pps), .rxd_a(rxd_a), .rxd_b(rxd_b),
        .txd_a(txd_a), .txd_b(txd_b), .standby(standby), .ant_status(ant_status),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    gps_host_side host (
        .ref_clk(ref_clk), .txd_a(txd_a), .txd_b(txd_b), .ext_reset_n(ext_reset_n),
        .run_standby(run_standby), .ant_open(ant_open), .ant_short(ant_short),
        .rxd_a(rxd_a), .rxd_b(rxd_b));

    // A 50 ns clock and a free cycle count for timing pulse positions.
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; ready, read data and error are all taken at the rising edge.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) num_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Counts high cycles of the pulse output and notes where the last pulse rose.
    task watch(output int h, output int rise);
        logic last;
        h = 0;
        rise = -1;
        repeat (200) @(posedge ref_clk);
        last = pps;
        repeat (400) begin
            @(negedge ref_clk);
            if (pps === 1'b1) h++;
            if (pps === 1'b1 && last !== 1'b1) rise = cyc % 200;
            last = pps;
        end
    endtask

    task report_and_stop;
        $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_defaults;
        apb(1'b0, gps_pins_pkg::REG_PULSE_WIDTH, 32'h0);
        check("width", rd, 32'd84);
        apb(1'b0, gps_pins_pkg::REG_BAUD_A, 32'h0);
        check("baud a", rd, 32'd520);
        apb(1'b0, gps_pins_pkg::REG_BAUD_B, 32'h0);
        check("baud b", rd, 32'd4166);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped", {rd[30:0], err}, 32'h1);
        $display("defaults done");
    endtask

    task t_antenna;
        logic [1:0] tbl [5];
        tbl = '{2'b11, 2'b10, 2'b01, 2'b00, 2'b00};
        for (int i = 0; i < 5; i++) begin
            host.set_ant(i < 4, tbl[i][1], tbl[i][0]);
            repeat (6) @(posedge ref_clk);
            apb(1'b0, gps_pins_pkg::REG_STATUS, 32'h0);
            check("status", rd, {30'h0, 2'(i == 4 ? 1 : i ^ 1)});
            check("ant pins", {30'h0, ant_status}, {30'h0, 2'(i == 4 ? 1 : i ^ 1)});
        end
        $display("antenna done");
    endtask

    task t_standby;
        host.set_run(1'b0);
        repeat (6) @(posedge ref_clk);
        check("amp off", {31'h0, ext_amp_enable_n, standby}, 32'h3);
        watch(hi, r1);
        check("no pulse", hi, 0);
        host.set_run(1'b1);
        repeat (6) @(posedge ref_clk);
        check("amp on", {31'h0, ext_amp_enable_n, standby}, 32'h0);
        $display("standby done");
    endtask

    task t_pulse;
        apb(1'b1, gps_pins_pkg::REG_PULSE_WIDTH, 32'd5);
        apb(1'b1, gps_pins_pkg::REG_CABLE_DELAY, 32'd10);
        watch(hi, r1);
        check("width 5", hi, 10);
        apb(1'b1, gps_pins_pkg::REG_CABLE_DELAY, 32'd40);
        watch(hi, r2);
        check("delay", (r2 - r1 + 200) % 200, 30);
        apb(1'b1, gps_pins_pkg::REG_CTRL, 32'h1);
        watch(hi, r1);
        check("inverted", hi, 390);
        apb(1'b1, gps_pins_pkg::REG_CTRL, 32'h2);
        watch(hi, r1);
        check("mode off", hi, 0);
        apb(1'b1, gps_pins_pkg::REG_CTRL, 32'h4);
        watch(hi, r1);
        check("gated open", hi, 0);
        host.set_ant(1'b1, 1'b1, 1'b0);
        watch(hi, r1);
        check("gated normal", hi, 10);
        $display("pulse done");
    endtask

    task t_serial;
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, gps_pins_pkg::REG_BAUD_A + 8'(4 * p), 32'd8);
            apb(1'b1, gps_pins_pkg::REG_UART_A + 8'(4 * p), 32'h5a + p);
            for (int n = 0; n < 60 && rd[9] !== 1'b1; n++) begin
                apb(1'b0, gps_pins_pkg::REG_UART_A + 8'(4 * p), 32'h0);
            end
            check("rx byte", rd, 32'h25a + p);
            apb(1'b0, gps_pins_pkg::REG_UART_A + 8'(4 * p), 32'h0);
            check("rx cleared", rd[9], 32'h0);
        end
        $display("serial done");
    endtask

    task t_ext_reset;
        apb(1'b1, gps_pins_pkg::REG_PULSE_WIDTH, 32'd7);
        host.reset_pulse(4);
        repeat (6) @(posedge ref_clk);
        apb(1'b0, gps_pins_pkg::REG_PULSE_WIDTH, 32'h0);
        check("short low", rd, 32'd7);
        host.reset_pulse(12);
        repeat (6) @(posedge ref_clk);
        apb(1'b0, gps_pins_pkg::REG_PULSE_WIDTH, 32'h0);
        check("reset width", rd, 32'd84);
        // A second power-on reset in mid-run must bring the default width back too.
        apb(1'b1, gps_pins_pkg::REG_PULSE_WIDTH, 32'd7);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        apb(1'b0, gps_pins_pkg::REG_PULSE_WIDTH, 32'h0);
        check("power-on width", rd, 32'd84);
        $display("reset done");
    endtask

    // Main sequence: power-on reset, then each scenario in turn.
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_defaults();
        t_antenna();
        t_standby();
        t_pulse();
        t_serial();
        t_ext_reset();
        report_and_stop();
    end

    // Cuts a hang short well past the few thousand cycles the scenarios need.
    initial begin
        #(50 * 50000);
        num_errors++;
        report_and_stop();
    end
endmodule
